// [dac_link_host.sv]
// Serial controller driving the dual DAC link, commanded over Avalon-MM
`timescale 1ns/1ns
`include "dac_link_map.svh"
module dac_link_host
    import dac_link_pkg::*;
(
    // System side
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Avalon-MM slave
    input  wire logic [`REG_ADDR_W-1:0] address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    output logic [31:0]                 readdata,
    output logic                        waitrequest,
    // Link to the DAC
    dac_link_if.host                    link
);

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    tx_state_t             state_ff;
    logic                  wait_ff;
    logic [31:0]           rdata_ff;
    logic                  holdLow_ff;
    logic [`FRM_BITS-1:0]  lastWord_ff;
    logic [`CNT_W-1:0]     pulseCnt_ff;
    logic                  strobeN_ff;
    wire                   busy;
    wire                   request;
    wire                   txHit;
    wire                   ctlHit;
    wire                   accept;
    wire                   startTx;
    wire                   ctlWrite;
    wire [31:0]            readMux;

    assign busy    = (state_ff != TX_IDLE);
    assign request = (read || write) && wait_ff;
    assign txHit   = (address == `REG_TXWORD);
    assign ctlHit  = (address == `REG_CONTROL);
    // A word write stalls on waitrequest until the previous frame is out
    assign accept   = request && !(write && txHit && busy);
    assign startTx  = accept && write && txHit;
    assign ctlWrite = accept && write && ctlHit;
    assign readMux  = (address == `REG_STATUS) ? {lastWord_ff, 14'h0, ~strobeN_ff, busy} :
                      ctlHit ? {31'h0, holdLow_ff} : 32'h0;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
        end
        else
        begin
            wait_ff  <= !accept;
            rdata_ff <= (accept && read) ? readMux : 32'h0;
        end
    end

    assign waitrequest = wait_ff;
    assign readdata    = rdata_ff;

    // ----------------------------------------
    // Load strobe
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            holdLow_ff  <= 1'b0;
            pulseCnt_ff <= '0;
            strobeN_ff  <= 1'b1;
        end
        else
        begin
            if (ctlWrite)
            begin
                holdLow_ff <= writedata[`CTL_HOLD_BIT];
            end
            if (ctlWrite && writedata[`CTL_PULSE_BIT])
            begin
                pulseCnt_ff <= `CNT_W'(`LOAD_PULSE_CYC);
            end
            else if (pulseCnt_ff != '0)
            begin
                pulseCnt_ff <= pulseCnt_ff - `CNT_W'(1);
            end
            // Long enough for the far end's three-stage sampling
            strobeN_ff <= !(holdLow_ff || (pulseCnt_ff != '0));
        end
    end

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    logic [`CNT_W-1:0]     halfCnt_ff;
    logic [`FRM_BITS-1:0]  shift_ff;
    logic [`FRM_CNT_W-1:0] edgesLeft_ff;
    logic                  sclk_ff;
    logic                  selN_ff;
    logic                  abortReq_ff;
    wire                   tick;

    assign tick = (halfCnt_ff == `CNT_W'(`SCLK_HALF_CYC - 1));

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            halfCnt_ff   <= '0;
            state_ff     <= TX_IDLE;
            shift_ff     <= '0;
            lastWord_ff  <= '0;
            edgesLeft_ff <= '0;
            sclk_ff      <= 1'b1;
            selN_ff      <= 1'b1;
            abortReq_ff  <= 1'b0;
        end
        else
        begin
            halfCnt_ff  <= tick ? '0 : halfCnt_ff + `CNT_W'(1);
            abortReq_ff <= (abortReq_ff || (ctlWrite && writedata[`CTL_ABORT_BIT])) && busy;
            if (startTx)
            begin
                lastWord_ff <= writedata[`FRM_BITS-1:0];
                shift_ff    <= writedata[`FRM_BITS-1:0];
            end
            unique case (state_ff)
                TX_IDLE:
                begin
                    if (startTx)
                    begin
                        selN_ff      <= 1'b0;
                        edgesLeft_ff <= `FRM_FULL_CNT;
                        state_ff     <= TX_SETUP;
                    end
                end
                TX_SETUP:
                begin
                    if (tick)
                    begin
                        sclk_ff      <= 1'b0;
                        edgesLeft_ff <= edgesLeft_ff - `FRM_CNT_W'(1);
                        state_ff     <= TX_SHIFT;
                    end
                end
                TX_SHIFT:
                begin
                    if (abortReq_ff)
                    begin
                        sclk_ff  <= 1'b1;
                        state_ff <= TX_DONE;
                    end
                    else if (tick && !sclk_ff)
                    begin
                        sclk_ff <= 1'b1;
                        if (edgesLeft_ff == '0)
                        begin
                            state_ff <= TX_DONE;
                        end
                        else
                        begin
                            shift_ff <= {shift_ff[`FRM_BITS-2:0], 1'b0};
                        end
                    end
                    else if (tick)
                    begin
                        sclk_ff      <= 1'b0;
                        edgesLeft_ff <= edgesLeft_ff - `FRM_CNT_W'(1);
                    end
                end
                TX_DONE:
                begin
                    if (tick)
                    begin
                        selN_ff  <= 1'b1;
                        state_ff <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.frameSelN            = selN_ff;
    assign link.serialClk            = sclk_ff;
    assign link.serialData           = shift_ff[`FRM_BITS-1];
    assign link.output_load_strobe_n = strobeN_ff;

endmodule // dac_link_host

// [dac_link_map.svh]
// Register offsets, frame fields and timing counts of the dual DAC link
`ifndef DAC_LINK_MAP_SVH
`define DAC_LINK_MAP_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define FRM_BITS        16
`define FRM_CNT_W       5
`define FRM_LAST_IDX    5'h0f
`define FRM_FULL_CNT    5'h10
`define FRM_SEL_BIT     15
`define FRM_BUF_BIT     14
`define FRM_MODE_HI     13
`define FRM_MODE_LO     12
`define FRM_DATA_MSB    11
`define DAC_RESOLUTION  12
`define DAC_CODE_W      12

// ----------------------------------------
// Power-on values
// ----------------------------------------
`define RST_CODE        12'h000
`define RST_MODE        2'h0
`define RST_BUF         1'h0

// ----------------------------------------
// Controller registers (byte addresses)
// ----------------------------------------
`define REG_ADDR_W      4
`define REG_TXWORD      4'h0
`define REG_CONTROL     4'h4
`define REG_STATUS      4'h8
`define CTL_HOLD_BIT    0
`define CTL_PULSE_BIT   1
`define CTL_ABORT_BIT   2

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_NS      8
`define SCLK_HALF_NS    16
`define SCLK_HALF_CYC   (`SCLK_HALF_NS / `SYS_CLK_NS)
`define LOAD_PULSE_NS   64
`define LOAD_PULSE_CYC  ((`LOAD_PULSE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define CNT_W           4

`endif

// [dac_link_pkg.sv]
// Types shared by both ends of the dual DAC link
package dac_link_pkg;

    typedef enum logic [1:0]
    {
        MODE_NORMAL   = 2'h0,
        MODE_PD_1K    = 2'h1,
        MODE_PD_100K  = 2'h2,
        MODE_PD_HIZ   = 2'h3
    } out_mode_t;

    typedef enum logic [3:0]
    {
        TX_IDLE  = 4'h1,
        TX_SETUP = 4'h2,
        TX_SHIFT = 4'h4,
        TX_DONE  = 4'h8
    } tx_state_t;

endpackage

// [dac_link_if.sv]
// Three-wire serial link plus load strobe between controller and DAC
`timescale 1ns/1ns
interface dac_link_if;
    logic frameSelN;
    logic serialClk;
    logic serialData;
    logic output_load_strobe_n;

    modport device
    (
        input frameSelN,
        input serialClk,
        input serialData,
        input output_load_strobe_n
    );

    modport host
    (
        output frameSelN,
        output serialClk,
        output serialData,
        output output_load_strobe_n
    );
endinterface

// [dac_link_device.sv]
// Digital control of the dual voltage-output DAC: serial frame intake and double buffering
`timescale 1ns/1ns
`include "dac_link_map.svh"

module dac_link_device
    import dac_link_pkg::*;
(
    // System side
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    // Link from the controller
    dac_link_if.device                        link,
    // Channel state, index 0 is channel A; nets, as each channel drives its own slice
    output wire logic [1:0][`DAC_CODE_W-1:0]  inputCode,
    output wire logic [1:0][`DAC_CODE_W-1:0]  dacCode,
    output wire logic [1:0]                   refBuffered,
    output wire logic [1:0]                   shutdownModeHi,
    output wire logic [1:0]                   shutdownModeLo,
    output wire logic                         strobeLow
);

    // ----------------------------------------
    // Data field decode
    // ----------------------------------------
    // Variants with fewer bits keep the upper bits of the field
    function automatic logic [`DAC_CODE_W-1:0] dataField(input logic [`FRM_BITS-1:0] word);
        logic [`DAC_CODE_W-1:0] mask;
        mask = ~((`DAC_CODE_W'(1) << (`DAC_CODE_W - `DAC_RESOLUTION)) - `DAC_CODE_W'(1));
        return word[`FRM_DATA_MSB:0] & mask;
    endfunction

    // ----------------------------------------
    // Link-domain reset
    // ----------------------------------------
    // The link clock stops between frames, so captured state is cleared
    // asynchronously from a registered copy of the system reset.
    logic                  linkRst_ff;

    always_ff @(posedge sys_clk)
    begin
        linkRst_ff <= rst;
    end

    // ----------------------------------------
    // Serial intake (link clock, falling edge)
    // ----------------------------------------
    logic [`FRM_CNT_W-1:0] bitCnt_ff;
    logic [`FRM_BITS-1:0]  shift_ff;
    logic [`FRM_BITS-1:0]  frameWord_ff;
    logic                  doneToggle_ff;
    wire                   bitTaken;
    wire                   lastBit;
    wire [`FRM_BITS-1:0]   shiftNext;

    assign bitTaken  = (bitCnt_ff != `FRM_FULL_CNT);
    assign lastBit   = (bitCnt_ff == `FRM_LAST_IDX);
    assign shiftNext = {shift_ff[`FRM_BITS-2:0], link.serialData};

    // Select high holds the counter cleared, so a short frame never completes
    always_ff @(negedge link.serialClk or posedge link.frameSelN)
    begin
        if (link.frameSelN)
        begin
            bitCnt_ff <= '0;
            shift_ff  <= '0;
        end
        else if (bitTaken)
        begin
            bitCnt_ff <= bitCnt_ff + `FRM_CNT_W'(1);
            shift_ff  <= shiftNext;
        end
    end

    always_ff @(negedge link.serialClk or posedge linkRst_ff)
    begin
        if (linkRst_ff)
        begin
            frameWord_ff  <= '0;
            doneToggle_ff <= 1'b0;
        end
        else if (!link.frameSelN && lastBit)
        begin
            frameWord_ff  <= shiftNext;
            doneToggle_ff <= ~doneToggle_ff;
        end
    end

    // ----------------------------------------
    // Crossing into the system clock
    // ----------------------------------------
    // Bit 1 carries the frame toggle, bit 0 the load strobe level.
    // The frame word is stable for at least sixteen link edges after the
    // toggle flips, far longer than the three-stage crossing needs.
    logic [1:0]            sync1_ff;
    logic [1:0]            sync2_ff;
    logic [1:0]            sync3_ff;
    logic                  seenToggle_ff;
    logic                  strobeLow_ff;
    wire  [1:0]            agree;
    wire                   newFrame;
    wire                   frameChan;

    assign agree     = ~(sync2_ff ^ sync3_ff);
    assign newFrame  = agree[1] && (sync3_ff[1] != seenToggle_ff);
    assign frameChan = frameWord_ff[`FRM_SEL_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync1_ff <= 2'h1;
            sync2_ff <= 2'h1;
            sync3_ff <= 2'h1;
        end
        else
        begin
            sync1_ff <= {doneToggle_ff, link.output_load_strobe_n};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            seenToggle_ff <= 1'b0;
            strobeLow_ff  <= 1'b0;
        end
        else
        begin
            if (agree[1])
            begin
                seenToggle_ff <= sync3_ff[1];
            end
            if (agree[0])
            begin
                strobeLow_ff <= ~sync3_ff[0];
            end
        end
    end

    assign strobeLow = strobeLow_ff;

    // ----------------------------------------
    // Per-channel input and DAC registers
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            logic [`DAC_CODE_W-1:0] inCode_ff;
            logic [`DAC_CODE_W-1:0] dacCode_ff;
            logic                   refBuf_ff;
            out_mode_t              mode_ff;
            logic                   pending_ff;
            wire                    writeHit;
            wire                    loadHit;
            wire                    nxt_pending;

            assign writeHit    = newFrame && (frameChan == 1'(ch));
            assign loadHit     = strobeLow_ff && pending_ff;
            // A write in the same cycle as a load stays pending for the next one
            assign nxt_pending = writeHit || (pending_ff && !loadHit);

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    inCode_ff  <= `RST_CODE;
                    dacCode_ff <= `RST_CODE;
                    refBuf_ff  <= `RST_BUF;
                    mode_ff    <= out_mode_t'(`RST_MODE);
                    pending_ff <= 1'b0;
                end
                else
                begin
                    pending_ff <= nxt_pending;
                    if (writeHit)
                    begin
                        inCode_ff <= dataField(frameWord_ff);
                        refBuf_ff <= frameWord_ff[`FRM_BUF_BIT];
                        mode_ff   <= out_mode_t'(frameWord_ff[`FRM_MODE_HI:`FRM_MODE_LO]);
                    end
                    // A frame writes the input code along with the mode; only a load touches the DAC code
                    if (loadHit)
                    begin
                        dacCode_ff <= inCode_ff;
                    end
                end
            end

            assign inputCode[ch]      = inCode_ff;
            assign dacCode[ch]        = dacCode_ff;
            assign refBuffered[ch]    = refBuf_ff;
            assign shutdownModeHi[ch] = mode_ff[1];
            assign shutdownModeLo[ch] = mode_ff[0];
        end
    endgenerate

endmodule // dac_link_device

// [dac_link_asserts.sv]
// Concurrent checks on the serial link between the DAC controller and the DAC
`timescale 1ns/1ns
`include "dac_link_map.svh"
module dac_link_asserts
(
    // Clock and reset
    input wire logic                        sys_clk,
    input wire logic                        rst,
    // Link wires
    input wire logic                        frameSelN,
    input wire logic                        serialClk,
    input wire logic                        serialData,
    input wire logic                        output_load_strobe_n,
    // Device registers
    input wire logic [1:0][`DAC_CODE_W-1:0] inputCode,
    input wire logic [1:0][`DAC_CODE_W-1:0] dacCode,
    input wire logic                        strobeLow
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic       clkPrev_ff;
    logic [4:0] fallCnt_ff;
    logic [4:0] doneAge_ff;
    wire        clkFell = clkPrev_ff && !serialClk && !frameSelN;

    // Age saturates at 31, which also stands for no frame seen yet
    always_ff @(posedge sys_clk)
    begin
        clkPrev_ff <= serialClk;
        if (rst || frameSelN)
            fallCnt_ff <= 5'h00;
        else if (clkFell && fallCnt_ff != 5'h1f)
            fallCnt_ff <= fallCnt_ff + 5'h01;
        if (rst)
            doneAge_ff <= 5'h1f;
        else if (clkFell && fallCnt_ff == 5'h0f)
            doneAge_ff <= 5'h00;
        else if (doneAge_ff != 5'h1f)
            doneAge_ff <= doneAge_ff + 5'h01;
    end

    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_frame_open;
        $fell(frameSelN) ##0 serialClk;
    endsequence

    sequence s_first_fall;
        ##[1:4] !serialClk;
    endsequence

    a_frame_start: assert property (s_frame_open |-> s_first_fall)
        else $error("no serial clock fall soon after frame open");
    a_idle_clock: assert property (frameSelN [*4] |-> serialClk)
        else $error("serial clock moved outside a frame");
    a_data_stable: assert property ($fell(serialClk) && !frameSelN |-> $stable(serialData))
        else $error("serial data changed at a sampling edge");
    a_count_bound: assert property (fallCnt_ff <= 5'h10)
        else $error("more than sixteen clock falls in a frame");
    a_input_cause: assert property (!$stable(inputCode) |-> doneAge_ff <= 5'h08)
        else $error("input register changed without a complete frame");
    a_strobe_seen: assert property ($fell(output_load_strobe_n) |-> ##[2:5] strobeLow)
        else $error("load strobe not seen by the device");
    a_dac_hold: assert property (output_load_strobe_n [*8] |-> $stable(dacCode))
        else $error("DAC register changed while strobe high");
    a_reg_reset: assert property ($fell(rst) |-> inputCode == '0 && dacCode == '0)
        else $error("registers not zero after reset");
endmodule // dac_link_asserts

// [tb_top.sv]
// Self-checking bench: controller and DAC joined over the serial link
`timescale 1ns/1ns
`include "dac_link_map.svh"
module tb_top;
    import dac_link_pkg::*;

    logic                   sys_clk = 1'b0;
    logic                   rst = 1'b1;
    logic [3:0]             address = 4'h0;
    logic                   read = 1'b0;
    logic                   write = 1'b0;
    logic [31:0]            writedata = 32'h0;
    logic [31:0]            readdata;
    logic                   waitrequest;
    logic [1:0][11:0]       inputCode;
    logic [1:0][11:0]       dacCode;
    logic [1:0]             refBuffered;
    logic [1:0]             shutdownModeHi;
    logic [1:0]             shutdownModeLo;
    logic                   strobeLow;
    logic [31:0]            rd;
    logic [3:0][11:0]       codes = {12'h7ff, 12'h800, 12'h000, 12'hfff};
    int                     failures = 0;
    int                     num_checks = 0;

    dac_link_if linkBus();

    dac_link_host dac_link_host_inst (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .link(linkBus));

    dac_link_device dac_link_device_inst (.sys_clk(sys_clk), .rst(rst), .link(linkBus),
        .inputCode(inputCode), .dacCode(dacCode), .refBuffered(refBuffered),
        .shutdownModeHi(shutdownModeHi), .shutdownModeLo(shutdownModeLo), .strobeLow(strobeLow));

    dac_link_asserts dac_link_asserts_inst (.sys_clk(sys_clk), .rst(rst), .frameSelN(linkBus.frameSelN),
        .serialClk(linkBus.serialClk), .serialData(linkBus.serialData),
        .output_load_strobe_n(linkBus.output_load_strobe_n), .inputCode(inputCode), .dacCode(dacCode),
        .strobeLow(strobeLow));

    always #4 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is sampled low; bench watchdog bounds the wait
    task avAccess(input logic isWr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address   <= a;
        writedata <= d;
        write     <= isWr;
        read      <= !isWr;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    // Input register lands on the same clock edge that drops the busy flag
    task sendFrame(input logic [15:0] w);
        avAccess(1'b1, `REG_TXWORD, {16'h0000, w});
        for (int i = 0; i < 100; i++)
        begin
            avAccess(1'b0, `REG_STATUS, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        // A frame that never ends counts as a mismatch rather than passing silently
        chk(rd[0], 1'b0);
        repeat (8) @(posedge sys_clk);
    endtask

    // ----------------------------------------
    // Watchdog and tests
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        summarize;
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        chk({inputCode, dacCode, refBuffered, shutdownModeHi, shutdownModeLo, strobeLow}, 64'h0);
        avAccess(1'b0, `REG_CONTROL, 32'h0);
        chk(rd, 32'h0);
        sendFrame(16'h5abc);
        chk({inputCode[0], refBuffered[0], shutdownModeHi[0], shutdownModeLo[0]}, {12'habc, 3'b101});
        chk(dacCode, 24'h0);
        avAccess(1'b0, `REG_STATUS, 32'h0);
        chk(rd[31:16], 16'h5abc);
        for (int m = 0; m < 4; m++)
        begin
            sendFrame({1'b1, m[0], m[1:0], codes[m]});
            chk({inputCode[1], refBuffered[1], shutdownModeHi[1], shutdownModeLo[1]}, {codes[m], m[0], m[1:0]});
            chk({inputCode[0], refBuffered[0], shutdownModeLo[0]}, {12'habc, 2'b11});
        end
        chk(dacCode, 24'h0);
        avAccess(1'b1, `REG_CONTROL, 32'h2);
        repeat (24) @(posedge sys_clk);
        chk(dacCode, {12'h7ff, 12'habc});
        // Abort lands well before the sixteenth fall
        avAccess(1'b1, `REG_TXWORD, 32'h0123);
        repeat (10) @(posedge sys_clk);
        avAccess(1'b1, `REG_CONTROL, 32'h4);
        repeat (40) @(posedge sys_clk);
        chk({inputCode, shutdownModeLo[0]}, {12'h7ff, 12'habc, 1'b1});
        avAccess(1'b1, `REG_CONTROL, 32'h1);
        sendFrame(16'h0456);
        chk(dacCode[0], 12'h456);
        avAccess(1'b0, `REG_CONTROL, 32'h0);
        chk(rd[0], 1'b1);
        avAccess(1'b0, `REG_STATUS, 32'h0);
        chk(rd[1:0], 2'b10);
        avAccess(1'b1, `REG_CONTROL, 32'h0);
        sendFrame(16'h0321);
        chk({inputCode[0], dacCode[0]}, {12'h321, 12'h456});
        // Only channel A was written since the last load
        avAccess(1'b1, `REG_CONTROL, 32'h2);
        repeat (24) @(posedge sys_clk);
        chk(dacCode, {12'h7ff, 12'h321});
        avAccess(1'b1, 4'hc, 32'hffff_ffff);
        avAccess(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        summarize;
    end
endmodule // tb_top
